/* design/flash_seq_map.svh */
/*
 * Constants for the flash command sequencer: register offsets, field
 * positions, reset values, command bytes and timing counts.
 * Assumes a 125 MHz core clock; included by bare name.
 */
`ifndef FLASH_SEQ_MAP_SVH
`define FLASH_SEQ_MAP_SVH

// ==========================================================
// register offsets (byte addresses)
`define REG_CTRL        8'h00
`define REG_ADDR        8'h04
`define REG_DATA        8'h08
`define REG_STATUS      8'h0c
`define REG_IRQ_STAT    8'h10
`define REG_IRQ_EN      8'h14
`define REG_IRQ_CLR     8'h18
`define REG_RDDATA      8'h1c

// ==========================================================
// field positions
`define CTRL_GO_BIT     3
`define CTRL_CMD_LSB    0
`define CTRL_CEWR_BIT   4
`define ST_BUSY_BIT     0
`define ST_TMO_BIT      1
`define IRQ_DONE_BIT    0
`define IRQ_TMO_BIT     1
`define IRQ_EN_RST      2'h0

// ==========================================================
// command bytes and unlock addresses
`define ADDR_555        19'h00555
`define ADDR_2AA        19'h002aa
`define DAT_AA          8'haa
`define DAT_55          8'h55
`define DAT_A0          8'ha0
`define DAT_80          8'h80
`define DAT_30          8'h30
`define DAT_10          8'h10
`define DAT_24          8'h24
`define DAT_F0          8'hf0

// ==========================================================
// timing
`define CLK_MHZ         125
`define PROG_MAX_US     300
`define SECT_MAX_S      8
`define CHIP_MAX_S      64
`define PROG_MAX_CYC    (`PROG_MAX_US * `CLK_MHZ)
`define SECT_MAX_CYC    (`SECT_MAX_S * 1000000 * `CLK_MHZ)
// 64-bit product: the chip limit overflows a 32-bit int
`define CHIP_MAX_CYC    (64'd1000000 * `CHIP_MAX_S * `CLK_MHZ)
// bus phase count: 35/45 ns pulse, 45 ns = 5.6 cycles rounded up to 6; a phase lasts 6 + 1 = 7 cycles
`define PHASE_CYC       4'd6
`define POLL_GAP_CYC    4'd12

`endif

/* design/flash_seq_pkg.sv */
/*
 * Types for the flash command sequencer.
 * Assumes flash_seq_map.svh holds all numbers except the command codes.
 */
package flash_seq_pkg;
    typedef enum logic [2:0] {
        CMD_PROGRAM = 3'h0,
        CMD_SECTOR  = 3'h1,
        CMD_CHIP    = 3'h2,
        CMD_PROTECT = 3'h3,
        CMD_UNPROT  = 3'h4,
        CMD_RESET   = 3'h5
    } cmd_t;

    typedef struct packed {
        logic [18:0] addr;
        logic [7:0]  dout;
        logic        doutEn_n;
        logic        ce_n;
        logic        we_n;
        logic        oe_n;
    } flash_pins_t;

    typedef struct packed {
        logic [7:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } sw_req_t;
endpackage

/* design/flash_bus_cycle.sv */
/*
 * One asynchronous flash bus cycle (write or read) on the pins.
 * Assumes the caller holds req steady until done pulses.
 */
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
module flash_bus_cycle
    import flash_seq_pkg::*;
(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic        start,
    input  wire logic        isWrite,
    input  wire logic        ceStrobe,
    input  wire logic [18:0] addr,
    input  wire logic [7:0]  wdata,
    input  wire logic [7:0]  pinData,
    output logic             done,
    output logic [7:0]       rdata,
    output flash_pins_t      pins
);
    typedef struct packed {
        logic        busy;
        logic        ceMode;
        logic [1:0]  phase;
        logic [3:0]  cnt;
        logic        done;
        logic [7:0]  rdata;
        flash_pins_t pins;
    } st_t;
    st_t s_r, s_nxt;

    always_comb begin
        s_nxt = s_r;
        s_nxt.done = 1'b0;
        if (!s_r.busy) begin
            if (start) begin
                s_nxt.busy = 1'b1;
                s_nxt.phase = 2'd0;
                s_nxt.cnt = `PHASE_CYC;
                s_nxt.pins.addr = addr;
                s_nxt.pins.dout = wdata;
                s_nxt.pins.doutEn_n = !isWrite;
                s_nxt.ceMode = isWrite && ceStrobe;
                if (isWrite && ceStrobe) begin
                    s_nxt.pins.we_n = 1'b0;
                end else if (isWrite) begin
                    s_nxt.pins.ce_n = 1'b0;
                end
            end
        end else if (s_r.cnt != 4'd0) begin
            s_nxt.cnt = s_r.cnt - 4'd1;
        end else begin
            s_nxt.phase = s_r.phase + 2'd1;
            s_nxt.cnt = `PHASE_CYC;
            case (s_r.phase)
                2'd0: begin
                    // strobe low phase
                    if (s_r.pins.doutEn_n) begin
                        s_nxt.pins.ce_n = 1'b0;
                        s_nxt.pins.oe_n = 1'b0;
                    end else if (!s_r.pins.we_n) begin
                        s_nxt.pins.ce_n = 1'b0;
                    end else begin
                        s_nxt.pins.we_n = 1'b0;
                    end
                end
                2'd1: begin
                    // each read ends by raising ce and oe
                    s_nxt.rdata = pinData;
                    s_nxt.pins.oe_n = 1'b1;
                    // the held strobe rises one phase later
                    if (s_r.pins.doutEn_n || s_r.ceMode) begin
                        s_nxt.pins.ce_n = 1'b1;
                    end else begin
                        s_nxt.pins.we_n = 1'b1;
                    end
                end
                default: begin
                    s_nxt.pins.we_n = 1'b1;
                    s_nxt.pins.ce_n = 1'b1;
                    s_nxt.pins.doutEn_n = 1'b1;
                    s_nxt.busy = 1'b0;
                    s_nxt.done = 1'b1;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '{busy: 1'b0, ceMode: 1'b0, phase: 2'd0, cnt: 4'd0, done: 1'b0, rdata: 8'h00,
                     pins: '{addr: 19'h00000, dout: 8'h00, doutEn_n: 1'b1,
                             ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1}};
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    assign done = s_r.done;
    assign rdata = s_r.rdata;
    assign pins = s_r.pins;
endmodule
`default_nettype wire

/* design/flash_seq_host.sv */
/*
 * Host-side command sequencer for an asynchronous byte-wide flash.
 * Software writes address, data and a command; the block issues the
 * unlock cycles, then (except for a reset) polls the toggle bit until it settles or a
 * timeout expires. Assumes the flash pins are sampled asynchronously.
 */
// Added by the designer: the strobed register port and the address map.
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
module flash_seq_host
    import flash_seq_pkg::*;
#(
    parameter int unsigned PROG_TMO = `PROG_MAX_CYC,
    parameter longint unsigned SECT_TMO = `SECT_MAX_CYC,
    parameter longint unsigned CHIP_TMO = `CHIP_MAX_CYC
)(
    input  wire logic        core_clk,
    input  wire logic        resetn,
    input  wire logic        clkEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [31:0] regWdata,
    input  wire logic        regWr,
    input  wire logic        regRd,
    output logic [31:0]      regRdata,
    output logic             irq,
    input  wire logic [7:0]  flashDin,
    output logic [18:0]      flashAddr,
    output logic [7:0]       flashDout,
    output logic             flashDoutEn_n,
    output logic             flashCe_n,
    output logic             flashWe_n,
    output logic             flashOe_n
);
    // ==========================================================
    // state
    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_WRITE = 6'b000010,
        S_POLL  = 6'b000100,
        S_GAP   = 6'b001000,
        S_DONE  = 6'b010000,
        S_WAIT  = 6'b100000
    } state_t;

    typedef struct packed {
        state_t      state;
        logic [2:0]  step;
        logic [2:0]  nSteps;
        cmd_t        cmd;
        logic        ceWrite;
        logic [18:0] addr;
        logic [7:0]  data;
        logic        busy;
        logic        tmo;
        logic [1:0]  irqStat;
        logic [1:0]  irqEn;
        logic        irq;
        logic [39:0] timer;
        logic        havePrev;
        logic [7:0]  prevRead;
        logic [7:0]  lastRead;
        logic [3:0]  gap;
        logic        cycStart;
        logic [31:0] rdata;
        logic [7:0]  din1;
        logic [7:0]  din2;
    } st_t;
    st_t s_r, s_nxt;

    logic        cycDone;
    logic [7:0]  cycRdata;
    flash_pins_t pins;
    logic [18:0] stepAddr;
    logic [7:0]  stepData;
    logic [39:0] limit;
    logic        doneEv;
    logic        tmoEv;

    // ==========================================================
    // command table
    always_comb begin
        stepAddr = `ADDR_555;
        stepData = `DAT_AA;
        case (s_r.step)
            3'd0: begin
                stepAddr = `ADDR_555;
                stepData = `DAT_AA;
            end
            3'd1: begin
                stepAddr = `ADDR_2AA;
                stepData = `DAT_55;
            end
            3'd2: begin
                stepAddr = `ADDR_555;
                case (s_r.cmd)
                    CMD_PROGRAM: stepData = `DAT_A0;
                    CMD_PROTECT, CMD_UNPROT: stepData = `DAT_24;
                    CMD_RESET: stepData = `DAT_F0;
                    default: stepData = `DAT_80;
                endcase
                if (s_r.cmd == CMD_PROGRAM) begin
                    stepAddr = `ADDR_555;
                end
            end
            3'd3: begin
                stepAddr = `ADDR_555;
                stepData = `DAT_AA;
                if (s_r.cmd == CMD_PROGRAM) begin
                    stepAddr = s_r.addr;
                    stepData = s_r.data;
                end else if (s_r.cmd == CMD_PROTECT) begin
                    stepAddr = {s_r.addr[18:7], 1'b0, 1'b1, s_r.addr[4:2], 1'b1, 1'b0};
                    stepData = s_r.data;
                end else if (s_r.cmd == CMD_UNPROT) begin
                    stepAddr = {s_r.addr[18:7], 1'b1, 1'b1, s_r.addr[4:2], 1'b1, 1'b0};
                    stepData = s_r.data;
                end
            end
            3'd4: begin
                stepAddr = `ADDR_2AA;
                stepData = `DAT_55;
            end
            default: begin
                stepAddr = (s_r.cmd == CMD_SECTOR) ? s_r.addr : `ADDR_555;
                stepData = (s_r.cmd == CMD_SECTOR) ? `DAT_30 : `DAT_10;
            end
        endcase
    end

    // per-command timeout; erase limit covers pre-programming
    always_comb begin
        case (s_r.cmd)
            CMD_SECTOR: limit = SECT_TMO[39:0];
            CMD_CHIP: limit = CHIP_TMO[39:0];
            default: limit = 40'(PROG_TMO);
        endcase
    end

    // ==========================================================
    // sequencer and registers
    always_comb begin
        s_nxt = s_r;
        s_nxt.cycStart = 1'b0;
        s_nxt.din1 = flashDin;
        s_nxt.din2 = s_r.din1;
        doneEv = 1'b0;
        tmoEv = 1'b0;
        s_nxt.rdata = 32'h00000000;
        if (regRd) begin
            case (regAddr)
                `REG_CTRL: s_nxt.rdata = {27'h0, s_r.ceWrite, 1'b0, s_r.cmd};
                `REG_ADDR: s_nxt.rdata = {13'h0, s_r.addr};
                `REG_DATA: s_nxt.rdata = {24'h0, s_r.data};
                `REG_STATUS: s_nxt.rdata = {30'h0, s_r.tmo, s_r.busy};
                `REG_IRQ_STAT: s_nxt.rdata = {30'h0, s_r.irqStat};
                `REG_IRQ_EN: s_nxt.rdata = {30'h0, s_r.irqEn};
                `REG_RDDATA: s_nxt.rdata = {24'h0, s_r.lastRead};
                default: s_nxt.rdata = 32'h00000000;
            endcase
        end
        if (s_r.state != S_IDLE && s_r.state != S_WAIT) begin
            s_nxt.timer = s_r.timer + 40'd1;
        end
        case (s_r.state)
            S_IDLE: begin
                if (regWr && regAddr == `REG_CTRL && regWdata[`CTRL_GO_BIT]) begin
                    s_nxt.cmd = cmd_t'(regWdata[2:0]);
                    s_nxt.ceWrite = regWdata[`CTRL_CEWR_BIT];
                    s_nxt.step = 3'd0;
                    case (cmd_t'(regWdata[2:0]))
                        CMD_SECTOR, CMD_CHIP: s_nxt.nSteps = 3'd5;
                        CMD_RESET: s_nxt.nSteps = 3'd2;
                        default: s_nxt.nSteps = 3'd3;
                    endcase
                    s_nxt.busy = 1'b1;
                    s_nxt.tmo = 1'b0;
                    s_nxt.timer = 40'd0;
                    s_nxt.havePrev = 1'b0;
                    s_nxt.cycStart = 1'b1;
                    s_nxt.state = S_WRITE;
                end
            end
            S_WRITE: begin
                if (cycDone) begin
                    s_nxt.step = s_r.step + 3'd1;
                    s_nxt.cycStart = 1'b1;
                    if (s_r.step == s_r.nSteps) begin
                        s_nxt.state = (s_r.cmd == CMD_RESET) ? S_DONE : S_POLL;
                    end
                end
            end
            S_POLL: begin
                if (cycDone) begin
                    s_nxt.lastRead = cycRdata;
                    s_nxt.prevRead = cycRdata;
                    s_nxt.havePrev = 1'b1;
                    if (s_r.havePrev && cycRdata[6] == s_r.prevRead[6]) begin
                        s_nxt.state = S_DONE;
                    end else if (s_r.timer >= limit) begin
                        s_nxt.tmo = 1'b1;
                        s_nxt.state = S_DONE;
                    end else begin
                        s_nxt.gap = `POLL_GAP_CYC;
                        s_nxt.state = S_GAP;
                    end
                end
            end
            S_GAP: begin
                s_nxt.gap = s_r.gap - 4'd1;
                if (s_r.gap == 4'd0) begin
                    s_nxt.cycStart = 1'b1;
                    s_nxt.state = S_POLL;
                end
            end
            S_DONE: begin
                s_nxt.busy = 1'b0;
                doneEv = 1'b1;
                tmoEv = s_r.tmo;
                s_nxt.state = S_WAIT;
            end
            S_WAIT: s_nxt.state = S_IDLE;
            default: s_nxt.state = S_IDLE;
        endcase
        if (regWr) begin
            case (regAddr)
                `REG_ADDR: s_nxt.addr = regWdata[18:0];
                `REG_DATA: s_nxt.data = regWdata[7:0];
                `REG_IRQ_EN: s_nxt.irqEn = regWdata[1:0];
                `REG_IRQ_CLR: s_nxt.irqStat = s_r.irqStat & ~regWdata[1:0];
                default: s_nxt.irqEn = s_r.irqEn;
            endcase
        end
        // set beats clear
        if (doneEv) begin
            s_nxt.irqStat[`IRQ_DONE_BIT] = 1'b1;
        end
        if (tmoEv) begin
            s_nxt.irqStat[`IRQ_TMO_BIT] = 1'b1;
        end
        s_nxt.irq = |(s_nxt.irqStat & s_nxt.irqEn);
    end

    // polls read at the programmed or sector address
    flash_bus_cycle u_cycle (
        .core_clk (core_clk),
        .resetn   (resetn),
        .clkEn    (clkEn),
        .start    (s_r.cycStart),
        .isWrite  (s_r.state == S_WRITE),
        .ceStrobe (s_r.ceWrite),
        .addr     ((s_r.state == S_WRITE) ? stepAddr : s_r.addr),
        .wdata    (stepData),
        .pinData  (s_r.din2),
        .done     (cycDone),
        .rdata    (cycRdata),
        .pins     (pins)
    );

    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            s_r <= '0;
            s_r.state <= S_IDLE;
            s_r.cmd <= CMD_PROGRAM;
        end else if (clkEn) begin
            s_r <= s_nxt;
        end
    end

    assign regRdata = s_r.rdata;
    assign irq = s_r.irq;
    assign flashAddr = pins.addr;
    assign flashDout = pins.dout;
    assign flashDoutEn_n = pins.doutEn_n;
    assign flashCe_n = pins.ce_n;
    assign flashWe_n = pins.we_n;
    assign flashOe_n = pins.oe_n;

    // ==========================================================
    // checks
    property p_poll_after_write;
        @(posedge core_clk) disable iff (!resetn)
        (s_r.state == S_WRITE && cycDone && s_r.step == s_r.nSteps && s_r.cmd != CMD_RESET
         && clkEn) |=> s_r.state == S_POLL;
    endproperty
    a_poll_after_write: assert property (p_poll_after_write) else $error("no poll");

    property p_irq_level;
        @(posedge core_clk) disable iff (!resetn)
        (clkEn && !regWr && doneEv && s_r.irqEn[`IRQ_DONE_BIT]) |=> irq;
    endproperty
    a_irq_level: assert property (p_irq_level) else $error("irq mismatch");

    property p_strobes_excl;
        @(posedge core_clk) disable iff (!resetn)
        !(!flashWe_n && !flashOe_n);
    endproperty
    a_strobes_excl: assert property (p_strobes_excl) else $error("we and oe low");

    property p_oe_in_poll;
        @(posedge core_clk) disable iff (!resetn)
        !flashOe_n |-> s_r.state == S_POLL;
    endproperty
    a_oe_in_poll: assert property (p_oe_in_poll) else $error("read outside poll");

    property p_ce_write_we;
        @(posedge core_clk) disable iff (!resetn)
        (s_r.state == S_WRITE && s_r.ceWrite && !flashCe_n) |-> !flashWe_n;
    endproperty
    a_ce_write_we: assert property (p_ce_write_we) else $error("we high in ce write");

    property p_tmo_limit;
        @(posedge core_clk) disable iff (!resetn)
        $rose(s_r.tmo) |-> s_r.timer >= limit;
    endproperty
    a_tmo_limit: assert property (p_tmo_limit) else $error("early timeout");

    c_done: cover property (@(posedge core_clk) disable iff (!resetn) doneEv && !tmoEv);
    c_tmo: cover property (@(posedge core_clk) disable iff (!resetn) tmoEv);
    c_erase: cover property (@(posedge core_clk) disable iff (!resetn)
        s_r.state == S_POLL && s_r.cmd == CMD_SECTOR);
endmodule
`default_nettype wire

/* sim/flash_dev_model.sv */
/*
 * Behavioural model of the byte-wide flash on the far side of the
 * sequencer: decodes command writes, runs timed internal operations
 * and answers status reads with toggling bits.
 * Assumes the host drives the active-low strobes; has no clock.
 */
`timescale 1ns/1ns
`default_nettype none
module flash_dev_model #(
    parameter int PROG_NS  = 7000,
    // erase shortened, real seconds too long
    parameter int ERASE_NS = 20000,
    parameter int PROT_NS  = 2000
)(
    input  wire logic [18:0] flashAddr,
    input  wire logic [7:0]  flashDout,
    input  wire logic        flashDoutEn_n,
    input  wire logic        flashCe_n,
    input  wire logic        flashWe_n,
    input  wire logic        flashOe_n,
    output logic [7:0]       flashDin
);
    logic [18:0] wAddr[$];
    logic [7:0]  wData[$];
    logic [7:0]  mem[logic [18:0]];
    logic [7:0]  prData;
    logic [18:0] lastRdAddr;
    logic        busy, isProg, tog, stuck, wrAct, rdAct;
    logic [1:0]  arm;
    int          rdCnt, ceCnt, busyNs;

    initial begin
        {busy, isProg, tog, stuck, wrAct, rdAct, arm} = '0;
        rdCnt = 0;
        ceCnt = 0;
        prData = 8'h00;
        flashDin = 8'h5a;
    end

    // ==========================================================
    // command decode
    task automatic commit(input logic [18:0] a, input logic [7:0] d);
        wAddr.push_back(a);
        wData.push_back(d);
        if (!flashWe_n)
            ceCnt++;
        if (arm == 2'd1) begin
            mem[a] = d;
            prData = d;
            startOp(1'b1, PROG_NS);
        end else if (arm == 2'd2) begin
            startOp(1'b0, PROT_NS);
        end else if (d == 8'h30 || (d == 8'h10 && a == 19'h00555)) begin
            foreach (mem[k]) mem[k] = 8'h00;
            mem.delete();
            startOp(1'b0, ERASE_NS);
        end
        arm = (arm != 2'd0) ? 2'd0 : (d == 8'ha0) ? 2'd1 : (d == 8'h24) ? 2'd2 : 2'd0;
    endtask

    task automatic startOp(input logic p, input int ns);
        isProg = p;
        busyNs = ns;
        busy = 1'b1;
    endtask

    // stuck holds an operation open so the host must time out
    always @(posedge busy) begin
        #(busyNs);
        wait (!stuck);
        busy = 1'b0;
    end

    // write ends at whichever strobe rises first
    always @(flashCe_n or flashWe_n) begin
        if (!flashCe_n && !flashWe_n && flashOe_n) begin
            wrAct = 1'b1;
        end else if (wrAct) begin
            wrAct = 1'b0;
            commit(flashAddr, flashDoutEn_n ? 8'hff : flashDout);
        end
    end

    // ==========================================================
    // status and array reads
    // toggle per access, no suspend
    always @(flashCe_n or flashOe_n) begin
        if (!flashCe_n && !flashOe_n && flashWe_n) begin
            if (!rdAct) begin
                rdAct = 1'b1;
                rdCnt++;
                lastRdAddr = flashAddr;
                tog = busy ? ~tog : tog;
                flashDin = busy ? {isProg ? ~prData[7] : 1'b0, tog, 6'h00}
                         : (mem.exists(flashAddr) ? mem[flashAddr] : 8'hff);
            end
        end else if (rdAct) begin
            // released bus: never leave the last value standing
            rdAct = 1'b0;
            flashDin = ~flashDin;
        end
    end
endmodule
`default_nettype wire

/* sim/testbench.sv */
/*
 * Self-checking bench for the flash command sequencer.
 * Assumes flash_dev_model on the pins and the map header on the path.
 */
`timescale 1ns/1ns
`default_nettype none
`include "flash_seq_map.svh"
module testbench;
    import flash_seq_pkg::*;
    logic        core_clk, resetn, clkEn, regWr, regRd, irq;
    logic        flashDoutEn_n, flashCe_n, flashWe_n, flashOe_n;
    logic [7:0]  regAddr, flashDin, flashDout;
    logic [31:0] regWdata, regRdata;
    logic [18:0] flashAddr;
    int          mismatches, compares;

    // short timeouts keep the run brief
    flash_seq_host #(.PROG_TMO(2000), .SECT_TMO(4000), .CHIP_TMO(4000)) uut (
        .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .irq(irq), .flashDin(flashDin), .flashAddr(flashAddr), .flashDout(flashDout),
        .flashDoutEn_n(flashDoutEn_n), .flashCe_n(flashCe_n), .flashWe_n(flashWe_n),
        .flashOe_n(flashOe_n));

    flash_dev_model flash (
        .flashAddr(flashAddr), .flashDout(flashDout), .flashDoutEn_n(flashDoutEn_n),
        .flashCe_n(flashCe_n), .flashWe_n(flashWe_n), .flashOe_n(flashOe_n),
        .flashDin(flashDin));

    // ==========================================================
    // helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected %s: expected %h, seen %h", name, exp, seen);
        end
    endtask

    task automatic chkWr(input int i, input logic [18:0] a, input logic [7:0] d);
        chk("flash write", {5'h0, flash.wAddr[i], flash.wData[i]}, {5'h0, a, d});
    endtask

    task automatic regW(input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regWdata <= d;
        regWr <= 1'b1;
        @(posedge core_clk);
        regWr <= 1'b0;
    endtask

    task automatic regR(input logic [7:0] a, output logic [31:0] d);
        @(posedge core_clk);
        regAddr <= a;
        regRd <= 1'b1;
        @(posedge core_clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask

    task automatic runCmd(input logic [2:0] cmd, input logic [18:0] a, input logic [7:0] d,
                          input logic ce);
        logic [31:0] v;
        flash.wAddr.delete();
        flash.wData.delete();
        flash.rdCnt = 0;
        flash.ceCnt = 0;
        regW(`REG_ADDR, {13'h0, a});
        regW(`REG_DATA, {24'h0, d});
        regW(`REG_CTRL, {27'h0, ce, 1'b1, cmd});
        regR(`REG_STATUS, v);
        chk("busy", v[0], 1'b1);
        // a second start while busy must be ignored
        regW(`REG_CTRL, 32'h8);
        for (int i = 0; i < 4000 && v[0]; i++)
            regR(`REG_STATUS, v);
        chk("busy drop", v[0], 1'b0);
    endtask

    // ==========================================================
    // scenarios
    task automatic testRegs;
        logic [31:0] v;
        regR(`REG_STATUS, v);
        chk("status", v, 32'h0);
        regR(`REG_IRQ_EN, v);
        chk("irq enable", v, 32'h0);
        regR(`REG_IRQ_STAT, v);
        chk("irq status", v, 32'h0);
        regR(8'h20, v);
        chk("unmapped", v, 32'h0);
        chk("irq", irq, 1'b0);
    endtask

    task automatic testProgram;
        logic [31:0] v;
        regW(`REG_IRQ_EN, 32'h3);
        runCmd(CMD_PROGRAM, 19'h12345, 8'h3c, 1'b0);
        chk("write count", flash.wData.size(), 4);
        chkWr(0, 19'h00555, 8'haa);
        chkWr(1, 19'h002aa, 8'h55);
        chkWr(2, 19'h00555, 8'ha0);
        chkWr(3, 19'h12345, 8'h3c);
        chk("status reads", flash.rdCnt >= 2, 1'b1);
        chk("poll address", flash.lastRdAddr, 19'h12345);
        regR(`REG_RDDATA, v);
        chk("final data", v, 32'h3c);
        chk("done irq", irq, 1'b1);
        regR(`REG_IRQ_STAT, v);
        chk("irq status", v, 32'h1);
        regW(`REG_IRQ_CLR, 32'h3);
        repeat (2) @(posedge core_clk);
        #1 chk("irq cleared", irq, 1'b0);
    endtask

    task automatic testErase(input logic [2:0] cmd, input logic ce);
        int n;
        runCmd(cmd, 19'h20000, 8'h00, ce);
        n = flash.wData.size();
        chk("write count", n, 6);
        chkWr(2, 19'h00555, 8'h80);
        chkWr(n - 2, 19'h002aa, 8'h55);
        if (cmd == CMD_SECTOR)
            chkWr(n - 1, 19'h20000, 8'h30);
        else
            chkWr(n - 1, 19'h00555, 8'h10);
        chk("strobe kind", flash.ceCnt, ce ? n : 0);
        regW(`REG_IRQ_CLR, 32'h3);
    endtask

    task automatic testProt(input logic [2:0] cmd, input logic b6);
        logic [18:0] a;
        int seen24;
        runCmd(cmd, 19'h30000, 8'h00, 1'b0);
        seen24 = 0;
        foreach (flash.wData[i])
            if (flash.wData[i] == 8'h24) seen24 = 1;
        chk("unlock 24h", seen24, 1);
        a = flash.wAddr[flash.wAddr.size() - 1];
        chk("sector bits", {a[6], a[5], a[1], a[0]}, {b6, 3'b110});
        chk("sector base", a[18:12], 7'h30);
        regW(`REG_IRQ_CLR, 32'h3);
    endtask

    task automatic testTimeout;
        logic [31:0] v;
        regW(`REG_IRQ_EN, 32'h0);
        flash.stuck = 1'b1;
        runCmd(CMD_PROGRAM, 19'h00100, 8'h5a, 1'b0);
        regR(`REG_STATUS, v);
        chk("timeout flag", v[1], 1'b1);
        regR(`REG_IRQ_STAT, v);
        chk("timeout event", v[1], 1'b1);
        chk("masked irq", irq, 1'b0);
        regW(`REG_IRQ_EN, 32'h2);
        repeat (2) @(posedge core_clk);
        #1 chk("timeout irq", irq, 1'b1);
        regW(`REG_IRQ_CLR, 32'h3);
        repeat (2) @(posedge core_clk);
        #1 chk("irq cleared", irq, 1'b0);
        flash.stuck = 1'b0;
    endtask

    task automatic testReset;
        logic [31:0] v;
        logic [21:0] p;
        flash.wAddr.delete();
        flash.wData.delete();
        regW(`REG_CTRL, 32'hd);
        repeat (30) @(posedge core_clk);
        clkEn <= 1'b0;
        #1 p = {flashAddr, flashCe_n, flashWe_n, flashOe_n};
        repeat (40) @(posedge core_clk);
        #1 chk("frozen pins", p, {flashAddr, flashCe_n, flashWe_n, flashOe_n});
        @(posedge core_clk);
        clkEn <= 1'b1;
        v = 32'h1;
        for (int i = 0; i < 200 && v[0]; i++)
            regR(`REG_STATUS, v);
        chk("write count", flash.wData.size(), 3);
        chkWr(2, 19'h00555, 8'hf0);
    endtask

    // ==========================================================
    // run control
    task automatic test_done;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    initial begin
        repeat (60000) @(posedge core_clk);
        mismatches++;
        test_done;
    end

    initial begin
        {resetn, regWr, regRd, regAddr, regWdata} = '0;
        clkEn = 1'b1;
        mismatches = 0;
        compares = 0;
        repeat (4) @(posedge core_clk);
        resetn <= 1'b1;
        testRegs;
        testProgram;
        testErase(CMD_SECTOR, 1'b0);
        testErase(CMD_CHIP, 1'b1);
        testProt(CMD_PROTECT, 1'b0);
        testProt(CMD_UNPROT, 1'b1);
        testTimeout;
        testReset;
        test_done;
    end
endmodule
`default_nettype wire
